/* File: hw/bpx_port.sv */
// Eight-pin bidirectional port with external interrupt and AHB-Lite registers
// Behaviour
// [R1] Eight pins, bit X controls pin X
// [R2] Input mode: data read returns pin level
// [R3] Data write in input mode only updates latch
// [R4] Software loads latch before switching to output
// [R5] Software avoids read-modify-write on data
// [R6] Input option: 0 floating, 1 pull-up
// [R7] Direction 0 option 1 raises interrupt request
// [R8] Qualified pin events ORed per vector
// [R9] Hidden request latch cleared by vector fetch
// [R10] Sensitivity write clears pending request
// [R11] Delivered only when enabled and unmasked
// [R12] Output mode drives latch, read returns latch
// [R13] Output option: 0 open-drain, 1 push-pull
// [R14] Peripheral claim overrides direction and option
// [R15] Peripheral output forces output, peripheral drive
// [R16] Peripheral input: pin level stays readable
// [R17] Shared peripheral pin kept floating input
// [R18] Input mode, peripheral output: read peripheral value
// [R19] Output mode, peripheral input sees latch
// [R20] No alternate function on interrupt pin
// [R21] Analog input pin set floating first
// [R22] Change interrupt pins only along adjacent states
// [R23] Low-power modes keep config; interrupt wakes
// [R24] True open-drain pins: no option variants
// [R25] Reset leaves every pin floating input
// [R26] No-pull-up group: floating interrupt input
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module bpx_port
  import bpx_pkg::*;
#(
  parameter int          NPINS      = 8,      // Pins on this port
  parameter logic [7:0]  TRUE_OD    = 8'h00,  // Pins that are true open-drain
  parameter logic [7:0]  NO_PULLUP  = 8'h00,  // Interrupt pins without pull-up
  parameter logic [7:0]  IRQ_CAPABLE = 8'hFF  // Pins able to raise interrupts
) (
  input  wire logic              CLK_IN,
  input  wire logic              SYS_RST_IN,
  // AHB-Lite slave
  input  wire logic              HSEL_IN,
  input  wire logic [7:0]        HADDR_IN,
  input  wire logic [1:0]        HTRANS_IN,
  input  wire logic              HWRITE_IN,
  input  wire logic [2:0]        HSIZE_IN,
  input  wire logic [31:0]       HWDATA_IN,
  input  wire logic              HREADY_IN,
  output logic      [31:0]       HRDATA_OUT,
  output logic                   HREADYOUT_OUT,
  output logic                   HRESP_OUT,
  // Pads
  input  wire logic [NPINS-1:0]  PIN_IN,
  output logic      [NPINS-1:0]  PIN_OUT,
  output logic      [NPINS-1:0]  PIN_OE_OUT,
  output logic      [NPINS-1:0]  PULLUP_EN_OUT,
  // Peripheral sharing
  input  wire logic [NPINS-1:0]  ALT_OUT_EN_IN,   // Peripheral claims pin as output
  input  wire logic [NPINS-1:0]  ALT_OUT_VAL_IN,  // Peripheral output value
  input  wire logic [NPINS-1:0]  ALT_PUSH_PULL_IN,// Peripheral drive style
  output logic      [NPINS-1:0]  ALT_IN_OUT,      // Value seen by peripheral input
  // Interrupt side
  input  wire logic              IRQ_MASK_IN,     // Global mask from cpu_flags_reg
  input  wire logic              VEC_FETCH_IN,    // Vector fetch pulse
  output logic                   IRQ_REQ_OUT,     // Request to controller
  output logic                   WAKE_OUT         // Wake from wait or halt
);
  // Elaboration check: one register word holds at most eight pin bits
  if (NPINS < 1 || NPINS > 8) begin : g_npins_check
    $error("NPINS must be 1..8");
  end

  // Register state
  logic [NPINS-1:0] data_q,  data_d;   // port_data_latch
  logic [NPINS-1:0] dir_q,   dir_d;    // port_direction
  logic [NPINS-1:0] opt_q,   opt_d;    // port_option
  logic [1:0]       sens_q,  sens_d;   // ext_irq_sensitivity_ctrl
  logic             pend_q,  pend_d;   // Hidden request latch
  logic [NPINS-1:0] prev_q,  prev_d;   // Previous pin levels for edges
  // Bus state
  bpx_state_t       st_q,    st_d;
  logic             wr_q,    wr_d;     // Pending write
  logic [7:0]       addr_q,  addr_d;   // Captured address
  logic [31:0]      rdata_q, rdata_d;  // Read data register

  logic [NPINS-1:0] pin_s;             // Synchronised pin level
  logic [NPINS-1:0] irq_en;            // Pins in interrupt mode
  logic [NPINS-1:0] drive_val;         // Value driven when enabled
  logic [NPINS-1:0] read_val;          // Data register read view
  logic             event_any;         // Qualified ORed event
  logic             sens_wr;           // Sensitivity written
  logic             take;              // Address phase accepted

  // Pins enter the clock domain through two flops
  bpx_sync #(.WIDTH(NPINS)) u_sync (
    .clk_in (CLK_IN),
    .rst_in (SYS_RST_IN),
    .d_in   (PIN_IN),
    .q_out  (pin_s)
  );

  // Pad drive per pin
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      drive_val[i]     = 1'b0;
      PIN_OE_OUT[i]    = 1'b0;
      PULLUP_EN_OUT[i] = 1'b0;
      read_val[i]      = pin_s[i];                               // [R2] [R16]
      ALT_IN_OUT[i]    = pin_s[i];
      if (ALT_OUT_EN_IN[i]) begin
        // Peripheral owns the pin as output                       // [R14]
        drive_val[i]  = ALT_OUT_VAL_IN[i];
        PIN_OE_OUT[i] = (ALT_PUSH_PULL_IN[i] && !TRUE_OD[i]) || !ALT_OUT_VAL_IN[i]; // [R15]
        if (!dir_q[i]) read_val[i] = ALT_OUT_VAL_IN[i];          // [R18]
      end else if (dir_q[i]) begin
        // Output mode drives the latch                           // [R12]
        drive_val[i]  = data_q[i];
        PIN_OE_OUT[i] = (opt_q[i] && !TRUE_OD[i]) || !data_q[i]; // [R13] [R24]
      end else begin
        // Input mode: pull-up on option 1 except special pins    // [R6] [R26]
        PULLUP_EN_OUT[i] = opt_q[i] && !TRUE_OD[i] && !NO_PULLUP[i];
      end
      if (dir_q[i]) begin
        read_val[i]   = data_q[i];                               // [R12]
        ALT_IN_OUT[i] = data_q[i];                               // [R19]
      end
    end
  end
  assign PIN_OUT = drive_val;

  // Interrupt qualification and OR
  always_comb begin
    event_any = 1'b0;
    for (int i = 0; i < NPINS; i++) begin
      irq_en[i] = !dir_q[i] && opt_q[i] && IRQ_CAPABLE[i] && !TRUE_OD[i]; // [R7]
      // Falling-low mode requests on every cycle that the pin stays low;
      // edge modes compare the level with the one seen a cycle earlier
      case (bpx_sens_t'(sens_q))
        BPX_SENS_FALL_LOW: if (irq_en[i] && !pin_s[i]) event_any = 1'b1;
        BPX_SENS_RISE: if (irq_en[i] && pin_s[i] && !prev_q[i]) event_any = 1'b1;
        BPX_SENS_FALL: if (irq_en[i] && !pin_s[i] && prev_q[i]) event_any = 1'b1;
        default:       if (irq_en[i] && (pin_s[i] != prev_q[i])) event_any = 1'b1; // [R8]
      endcase
    end
  end

  // Request latch next state; new events win over the fetch clear
  always_comb begin
    pend_d = pend_q;
    prev_d = pin_s;
    if (sens_wr) pend_d = 1'b0;                                  // [R10]
    else if (event_any) pend_d = 1'b1;
    else if (VEC_FETCH_IN) pend_d = 1'b0;                        // [R9]
  end
  assign IRQ_REQ_OUT = pend_q && !IRQ_MASK_IN;                   // [R11]
  assign WAKE_OUT    = pend_q;                                   // [R23]

  // AHB-Lite phase tracking and register writes
  // Accepted when selected, bus ready and NONSEQ or SEQ; transfer size is ignored
  assign take    = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  assign sens_wr = (st_q == BPX_ST_DATA) && wr_q && (addr_q == BPX_OFF_SENS);
  always_comb begin
    st_d    = st_q;
    wr_d    = wr_q;
    addr_d  = addr_q;
    rdata_d = rdata_q;
    data_d  = data_q;
    dir_d   = dir_q;
    opt_d   = opt_q;
    sens_d  = sens_q;
    // Write completes in its data phase
    if (st_q == BPX_ST_DATA && wr_q) begin
      if (addr_q == BPX_OFF_DATA) begin
        data_d = HWDATA_IN[NPINS-1:0];                           // [R3] [R1]
      end else if (addr_q == BPX_OFF_DIR) begin
        dir_d = HWDATA_IN[NPINS-1:0];                            // [R1]
      end else if (addr_q == BPX_OFF_OPT) begin
        opt_d = HWDATA_IN[NPINS-1:0];
      end else if (addr_q == BPX_OFF_SENS) begin
        sens_d = HWDATA_IN[1:0];
      end
    end
    // New address phase
    if (take) begin
      st_d   = BPX_ST_DATA;
      wr_d   = HWRITE_IN;
      addr_d = HADDR_IN;
      rdata_d = 32'h0000_0000;
      if (!HWRITE_IN) begin
        if (HADDR_IN == BPX_OFF_DATA) begin
          rdata_d[NPINS-1:0] = read_val;
        end else if (HADDR_IN == BPX_OFF_DIR) begin
          rdata_d[NPINS-1:0] = dir_q;
        end else if (HADDR_IN == BPX_OFF_OPT) begin
          rdata_d[NPINS-1:0] = opt_q;
        end else if (HADDR_IN == BPX_OFF_SENS) begin
          rdata_d[1:0] = sens_q;
        end else if (HADDR_IN == BPX_OFF_PIN) begin
          rdata_d[NPINS-1:0] = pin_s;
        end
      end
    end else if (HREADY_IN) begin
      st_d = BPX_ST_IDLE;
      wr_d = 1'b0;
    end
  end

  // Configuration registers; reset leaves every pin floating input
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      data_q  <= BPX_RST_DATA[NPINS-1:0];
      dir_q   <= BPX_RST_DIR[NPINS-1:0];                         // [R25]
      opt_q   <= BPX_RST_OPT[NPINS-1:0];                         // [R25]
      sens_q  <= BPX_RST_SENS;
    end else begin
      data_q  <= data_d;
      dir_q   <= dir_d;
      opt_q   <= opt_d;
      sens_q  <= sens_d;
    end
  end

  // Interrupt state; no interrupt pin exists after reset, so no false edge
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      pend_q  <= 1'b0;
      prev_q  <= '0;
    end else begin
      pend_q  <= pend_d;
      prev_q  <= prev_d;
    end
  end

  // Bus phase tracking and registered read data
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_q    <= BPX_ST_IDLE;
      wr_q    <= 1'b0;
      addr_q  <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      st_q    <= st_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      rdata_q <= rdata_d;
    end
  end

  // Zero-wait slave, always OKAY
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;
  assign HRDATA_OUT    = rdata_q;

  // Assertions
  property p_in_read;  // [R2]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (take && !HWRITE_IN && HADDR_IN == BPX_OFF_DATA && !dir_q[0] && !ALT_OUT_EN_IN[0])
      |=> HRDATA_OUT[0] == $past(pin_s[0]);
  endproperty
  a_in_read: assert property (p_in_read) else $error("input read wrong"); // [R2]

  property p_in_nodrive;  // [R3]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (!dir_q[0] && !ALT_OUT_EN_IN[0]) |-> !PIN_OE_OUT[0];
  endproperty
  a_in_nodrive: assert property (p_in_nodrive) else $error("input pin driven"); // [R3]

  property p_pullup;  // [R6]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (dir_q[0] || !opt_q[0] || ALT_OUT_EN_IN[0]) |-> !PULLUP_EN_OUT[0];
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrongly on"); // [R6]

  property p_od;  // [R13]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (dir_q[0] && !ALT_OUT_EN_IN[0] && !opt_q[0] && data_q[0]) |-> !PIN_OE_OUT[0];
  endproperty
  a_od: assert property (p_od) else $error("open-drain drove high"); // [R13]

  property p_out_low;  // [R12]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (dir_q[0] && !ALT_OUT_EN_IN[0] && !data_q[0]) |-> PIN_OE_OUT[0] && !PIN_OUT[0];
  endproperty
  a_out_low: assert property (p_out_low) else $error("output low not driven"); // [R12]

  property p_sens_clr;  // [R10]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      sens_wr |=> !pend_q;
  endproperty
  a_sens_clr: assert property (p_sens_clr) else $error("pending kept"); // [R10]

  property p_mask;  // [R11]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      IRQ_MASK_IN |-> !IRQ_REQ_OUT;
  endproperty
  a_mask: assert property (p_mask) else $error("request while masked"); // [R11]

  property p_fetch;  // [R9]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (VEC_FETCH_IN && !event_any) |=> !pend_q;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not clear"); // [R9]

  property p_alt;  // [R15]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (ALT_OUT_EN_IN[0] && !ALT_OUT_VAL_IN[0]) |-> PIN_OE_OUT[0] && !PIN_OUT[0];
  endproperty
  a_alt: assert property (p_alt) else $error("peripheral drive lost"); // [R15]

  property p_event_set;  // [R8]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (event_any && !sens_wr) |=> pend_q;
  endproperty
  a_event_set: assert property (p_event_set) else $error("event not latched"); // [R8]

  property p_no_irq_pin;  // [R7]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (irq_en == '0 && !pend_q) |=> !pend_q;
  endproperty
  a_no_irq_pin: assert property (p_no_irq_pin) else $error("request without pin"); // [R7]

  property p_out_read;  // [R12]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (take && !HWRITE_IN && HADDR_IN == BPX_OFF_DATA && dir_q[0])
      |=> HRDATA_OUT[0] == $past(data_q[0]);
  endproperty
  a_out_read: assert property (p_out_read) else $error("output read not latch"); // [R12]

  property p_alt_read;  // [R18]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (take && !HWRITE_IN && HADDR_IN == BPX_OFF_DATA && !dir_q[0] && ALT_OUT_EN_IN[0])
      |=> HRDATA_OUT[0] == $past(ALT_OUT_VAL_IN[0]);
  endproperty
  a_alt_read: assert property (p_alt_read) else $error("peripheral value not read"); // [R18]

  property p_alt_in;  // [R19]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      dir_q[0] |-> ALT_IN_OUT[0] == data_q[0];
  endproperty
  a_alt_in: assert property (p_alt_in) else $error("peripheral input not latch"); // [R19]

  property p_push_high;  // [R13]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (dir_q[2] && !ALT_OUT_EN_IN[2] && opt_q[2] && data_q[2] && !TRUE_OD[2])
      |-> PIN_OE_OUT[2] && PIN_OUT[2];
  endproperty
  a_push_high: assert property (p_push_high) else $error("push-pull high not driven"); // [R13]

  property p_data_wr;  // [R3]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (st_q == BPX_ST_DATA && wr_q && addr_q == BPX_OFF_DATA)
      |=> data_q == $past(HWDATA_IN[NPINS-1:0]);
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("latch write lost"); // [R3]
endmodule

/* File: pkg/bpx_pkg.sv */
// Package of constants for the bidirectional port block
package bpx_pkg;
  // Register byte offsets (aligned words)
  localparam logic [7:0] BPX_OFF_DATA  = 8'h00;  // port_data_latch
  localparam logic [7:0] BPX_OFF_DIR   = 8'h04;  // port_direction
  localparam logic [7:0] BPX_OFF_OPT   = 8'h08;  // port_option
  localparam logic [7:0] BPX_OFF_SENS  = 8'h0C;  // ext_irq_sensitivity_ctrl
  localparam logic [7:0] BPX_OFF_PIN   = 8'h10;  // Raw synchronised pin levels
  // Reset values
  localparam logic [7:0] BPX_RST_DATA  = 8'h00;
  localparam logic [7:0] BPX_RST_DIR   = 8'h00;
  localparam logic [7:0] BPX_RST_OPT   = 8'h00;
  localparam logic [1:0] BPX_RST_SENS  = 2'h0;
  // Sensitivity encodings
  typedef enum logic [1:0] {
    BPX_SENS_FALL_LOW  = 2'b00,
    BPX_SENS_RISE      = 2'b01,
    BPX_SENS_FALL      = 2'b10,
    BPX_SENS_BOTH      = 2'b11
  } bpx_sens_t;
  // Bus phase states
  typedef enum logic [0:0] {
    BPX_ST_IDLE = 1'b0,
    BPX_ST_DATA = 1'b1
  } bpx_state_t;
endpackage

/* File: hw/bpx_sync.sv */
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module bpx_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;  // First stage, read only by second stage
  logic [WIDTH-1:0] sync_q;  // Second stage
  // Two registered stages
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end
  assign q_out = sync_q;
endmodule

/* File: verif/bpx_pad_model.sv */
// Pad model: resolves each pin wire from the port, the outside driver and pull-up
`timescale 1ns/1ps
module bpx_pad_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] dut_val_in,
  input  wire logic [7:0] dut_oe_in,
  input  wire logic [7:0] pullup_in,
  input  wire logic [7:0] ext_val_in,
  input  wire logic [7:0] ext_oe_in,
  output logic      [7:0] pad_out
);
  logic [7:0] float_q;  // Pattern shown on undriven lines

  // Undriven lines change every cycle so no stale level can be read
  initial float_q = 8'h00;
  always @(posedge clk_in) begin
    float_q <= ~float_q;
  end

  // Port driver first, then outside driver, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dut_oe_in[i]) begin
        pad_out[i] = dut_val_in[i];
      end else if (ext_oe_in[i]) begin
        pad_out[i] = ext_val_in[i];
      end else if (pullup_in[i]) begin
        pad_out[i] = 1'b1;
      end else begin
        pad_out[i] = float_q[i];
      end
    end
  end
endmodule

/* File: verif/tb.sv */
// Self-checking testbench for the bidirectional port block
`timescale 1ns/1ps
module tb;
  import bpx_pkg::*;
  logic        clk, rst, hsel, hwrite, mask, fetch, rdy;
  logic [7:0]  haddr, pad, pin_out, oe, pu, ext_val, ext_oe, alt_en, alt_val, alt_pp, alt_in;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        resp, irq, wake;
  int          fail_count, cmp_count;

  // Clock of 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  bpx_port bpx_port_i (.CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(rdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(rdy), .HRESP_OUT(resp),
    .PIN_IN(pad), .PIN_OUT(pin_out), .PIN_OE_OUT(oe), .PULLUP_EN_OUT(pu),
    .ALT_OUT_EN_IN(alt_en), .ALT_OUT_VAL_IN(alt_val), .ALT_PUSH_PULL_IN(alt_pp),
    .ALT_IN_OUT(alt_in), .IRQ_MASK_IN(mask), .VEC_FETCH_IN(fetch), .IRQ_REQ_OUT(irq),
    .WAKE_OUT(wake));

  bpx_pad_model bpx_pad_model_i (.clk_in(clk), .dut_val_in(pin_out), .dut_oe_in(oe),
    .pullup_in(pu), .ext_val_in(ext_val), .ext_oe_in(ext_oe), .pad_out(pad));

  // Counts and verdict, then end of run
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait for the slave's ready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask

  // One single AHB-Lite transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    // Outputs change at the storing edge; look at them one edge later
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(x, exp);
  endtask

  // Bounded wait for a pending request, seen on the wake line
  task automatic wait_wake();
    int n;
    for (n = 0; n < 20 && wake !== 1'b1; n++) @(posedge clk);
    if (wake !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask

  initial begin
    {hsel, hwrite, mask, fetch, htrans, haddr, hwdata, hsize} = '0;
    {alt_en, alt_val, alt_pp} = '0;
    fail_count = 0;
    cmp_count = 0;
    ext_val = 8'hA5;
    ext_oe = 8'hFF;
    rst = 1'b1;
    tick(6);
    rst <= 1'b0;
    tick(4);
    rd(BPX_OFF_DIR, 8'h00);
    rd(BPX_OFF_OPT, 8'h00);
    chk(oe, 8'h00);
    chk(pu, 8'h00);
    chk(resp, 1'b0);
    rd(BPX_OFF_DATA, 8'hA5);
    rd(BPX_OFF_PIN, 8'hA5);
    rd(8'h20, 8'h00);
    $display("Test reset and input read done");
    wr(BPX_OFF_DATA, 8'h3C);
    chk(oe, 8'h00);
    rd(BPX_OFF_DATA, 8'hA5);
    ext_oe <= 8'h00;
    wr(BPX_OFF_DIR, 8'hFF);
    chk(oe, 8'hC3);
    chk(pin_out & oe, 8'h00);
    wr(BPX_OFF_OPT, 8'hFF);
    chk(oe, 8'hFF);
    chk(pin_out, 8'h3C);
    chk(pad, 8'h3C);
    rd(BPX_OFF_DATA, 8'h3C);
    chk(alt_in, 8'h3C);
    wr(BPX_OFF_OPT, 8'h00);
    ext_oe <= 8'hF0;
    ext_val <= 8'h50;
    wr(BPX_OFF_DIR, 8'h00);
    $display("Test output modes done");
    alt_en <= 8'h0F;
    alt_val <= 8'h0A;
    alt_pp <= 8'hFF;
    tick(4);
    chk(oe, 8'h0F);
    chk(pin_out & 8'h0F, 8'h0A);
    rd(BPX_OFF_DATA, 8'h5A);
    alt_pp <= 8'h00;
    tick(1);
    chk(oe, 8'h05);
    alt_en <= 8'h00;
    ext_oe <= 8'hFF;
    ext_val <= 8'h00;
    $display("Test alternate functions done");
    wr(BPX_OFF_SENS, 32'(BPX_SENS_RISE));
    wr(BPX_OFF_OPT, 8'h03);
    chk(pu, 8'h03);
    tick(4);
    chk(wake, 1'b0);
    ext_val <= 8'h02;
    wait_wake();
    chk(irq, 1'b1);
    fetch <= 1'b1;
    tick(1);
    fetch <= 1'b0;
    tick(2);
    chk(wake, 1'b0);
    mask <= 1'b1;
    ext_val <= 8'h03;
    wait_wake();
    chk(wake, 1'b1);
    chk(irq, 1'b0);
    wr(BPX_OFF_SENS, 32'(BPX_SENS_RISE));
    tick(1);
    chk(wake, 1'b0);
    mask <= 1'b0;
    ext_val <= 8'h07;
    tick(6);
    chk(wake, 1'b0);
    wr(BPX_OFF_SENS, 32'(BPX_SENS_FALL));
    rd(BPX_OFF_SENS, 32'(BPX_SENS_FALL));
    ext_val <= 8'h05;
    wait_wake();
    chk(irq, 1'b1);
    fetch <= 1'b1;
    tick(1);
    fetch <= 1'b0;
    tick(2);
    chk(wake, 1'b0);
    wr(BPX_OFF_SENS, 32'(BPX_SENS_BOTH));
    ext_val <= 8'h07;
    wait_wake();
    wr(BPX_OFF_SENS, 32'(BPX_SENS_FALL_LOW));
    chk(wake, 1'b0);
    ext_val <= 8'h06;
    wait_wake();
    fetch <= 1'b1;
    tick(1);
    fetch <= 1'b0;
    tick(2);
    chk(wake, 1'b1);
    ext_val <= 8'h07;
    tick(4);
    fetch <= 1'b1;
    tick(1);
    fetch <= 1'b0;
    tick(2);
    chk(wake, 1'b0);
    rd(BPX_OFF_PIN, 8'h07);
    $display("Test external interrupt done");
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(3);
    chk(oe, 8'h00);
    chk(pu, 8'h00);
    chk(wake, 1'b0);
    rd(BPX_OFF_OPT, 8'h00);
    rd(BPX_OFF_DATA, 8'h07);
    $display("Test reset in mid-run done");
    stop_test();
  end

  // Guard against a hung run
  initial begin
    #1000000;
    fail_count++;
    stop_test();
  end
endmodule
